// [common/ppo_pkg.sv]
// Purpose: shared constants for the port pin override block
// Assumes: one 8-pin port, AXI4-Lite register access, 50 MHz aclk
// Notes:   register offsets are byte addresses of aligned 32-bit words
//
// Function
// - deep sleep clamps digital inputs to ground
// - enabled external interrupt pins bypass the clamp
// - disabled edge interrupt pin high flags on wake
// - pull-ups off while reset is active
// - no pull-up override: pull-up when dir/out/global 010
// - pull-up override enable: override value decides alone
// - driver enable from override value or direction bit
// - drive override value ignores direction bit
// - driven value from override value or output bit
// - invert enable inverts the output bit
// - input gate from override or core sleep state
// - input gate override ignores sleep state
// - raw input tapped before synchroniser; consumer synchronises
// - analog path connects straight to the pad
// - strobes per port; clock, clamp, global bit shared
// - core control: bits 7,4,1,0 writable, rest read-only
// - global pull-up off disables all pull-ups not under override
// - direction one output, zero input with pull-up request
// - writing one to input bit toggles output bit
// - pin value read through a two-stage synchroniser
package ppo_pkg;
	localparam int          NPIN          = 8;
	localparam int          ADDR_W        = 5;
	localparam int          DATA_W        = 32;

	localparam logic [4:0]  OFS_DIR       = 5'h00;
	localparam logic [4:0]  OFS_OUT       = 5'h04;
	localparam logic [4:0]  OFS_PIN       = 5'h08;
	localparam logic [4:0]  OFS_CORE_CTRL = 5'h0C;
	localparam logic [4:0]  OFS_WAKE_FLAG = 5'h10;

	localparam int          BIT_DBG_OFF   = 7;
	localparam int          BIT_PU_OFF    = 4;
	localparam int          BIT_VEC_SEL   = 1;
	localparam int          BIT_VEC_UNLK  = 0;
	localparam logic [7:0]  CORE_WR_MASK  = 8'h93;
	localparam logic [7:0]  CORE_RESET    = 8'h00;
	localparam logic [7:0]  PIN_RESET     = 8'h00;

	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
	localparam logic [23:0] ZERO_PAD24    = 24'h00_0000;

	typedef logic [NPIN-1:0] ppo_pins_t;
endpackage : ppo_pkg

// [test/port_pin_override_test.sv]
// Purpose: self-checking bench of the pin override block
// Assumes: 50 MHz aclk, AXI4-Lite answers one cycle after acceptance
// Notes:   inputs change by non-blocking assignment after rising edges
`timescale 1ns/10ps
module port_pin_override_test;
	import ppo_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, deep_sleep = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic global_pullup_off, debug_port_off, vector_table_sel, vector_change_unlock;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	ppo_pins_t ext_int_en = 0, ext_int_edge_mode = 0, pullup_force_en = 0, pullup_force_val = 0;
	ppo_pins_t drive_force_en = 0, drive_force_val = 0, outval_force_en = 0, ext_en = 0;
	ppo_pins_t outval_force_val = 0, outbit_invert_en = 0, input_gate_force_en = 0, ext_val = 0;
	ppo_pins_t input_gate_force_val = 0, raw_pin_input, pad_analog_path, pad_in, pad_out;
	ppo_pins_t pad_oe, pad_pullup_en, wake_int_flag;
	int err_total = 0, checked = 0;
	logic [31:0] rd;
	logic [1:0] rs;
	always #10 aclk = ~aclk;
	ppo_port_pin_override uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .deep_sleep, .ext_int_en, .ext_int_edge_mode,
		.pullup_force_en, .pullup_force_val, .drive_force_en, .drive_force_val, .outval_force_en,
		.outval_force_val, .outbit_invert_en, .input_gate_force_en, .input_gate_force_val,
		.raw_pin_input, .pad_analog_path, .pad_in, .pad_out, .pad_oe, .pad_pullup_en,
		.global_pullup_off, .debug_port_off, .vector_table_sel, .vector_change_unlock,
		.wake_int_flag);
	ppo_pad_model u_pad (.aclk, .pad_out, .pad_oe, .pad_pullup_en, .ext_en, .ext_val, .pad_in);
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, k;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		{ta, tw, k} = 3'b000;
		while (!k) begin
			@(negedge aclk);
			ta = ta | (s_axi_awvalid & s_axi_awready);
			tw = tw | (s_axi_wvalid & s_axi_wready);
			k = s_axi_bvalid;
			if (k) chk(s_axi_bresp, er);
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [4:0] a);
		logic ta, k;
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		{ta, k} = 2'b00;
		while (!k) begin
			@(negedge aclk);
			ta = ta | (s_axi_arvalid & s_axi_arready);
			{k, rd, rs} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask : rdr
	task automatic t_pullup;
		for (int i = 0; i < 8; i++) begin
			wr(OFS_DIR, i[2], RESP_OKAY);
			wr(OFS_OUT, i[1], RESP_OKAY);
			wr(OFS_CORE_CTRL, {i[0], 4'h0}, RESP_OKAY);
			@(negedge aclk) chk(pad_pullup_en[0], i == 2);
		end
		@(posedge aclk) {pullup_force_en, pullup_force_val} <= 16'hFF55;
		@(negedge aclk) chk(pad_pullup_en, 8'h55);
		$display("pull-up test done");
	endtask : t_pullup
	task automatic t_reset;
		@(posedge aclk) {pullup_force_en, pullup_force_val} <= 16'h0000;
		wr(OFS_CORE_CTRL, ZERO_WORD, RESP_OKAY);
		wr(OFS_DIR, ZERO_WORD, RESP_OKAY);
		wr(OFS_OUT, 32'h0000_0001, RESP_OKAY);
		@(negedge aclk) chk(pad_pullup_en, 8'h01);
		@(posedge aclk) aresetn <= 1'b0;
		#1 chk(pad_pullup_en, 8'h00);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(OFS_DIR);
		chk(rd, ZERO_WORD);
		rdr(OFS_CORE_CTRL);
		chk(rd, CORE_RESET);
		$display("reset test done");
	endtask : t_reset
	task automatic t_drive;
		wr(OFS_DIR, 8'hFF, RESP_OKAY);
		wr(OFS_OUT, 8'hA5, RESP_OKAY);
		@(negedge aclk) chk({pad_oe, pad_out}, 16'hFFA5);
		rdr(OFS_PIN);
		chk(rd, 8'hA5);
		@(posedge aclk) outbit_invert_en <= 8'h0F;
		@(negedge aclk) chk(pad_out, 8'hAA);
		@(posedge aclk) {drive_force_en, drive_force_val} <= 16'hF030;
		{outval_force_en, outval_force_val} <= 16'hFF3C;
		@(negedge aclk) chk({pad_oe, pad_out}, 16'h3F3C);
		@(posedge aclk) {drive_force_en, outval_force_en, outbit_invert_en} <= 24'h0;
		wr(OFS_PIN, 8'h0F, RESP_OKAY);
		rdr(OFS_OUT);
		chk(rd, 8'hAA);
		$display("drive test done");
	endtask : t_drive
	task automatic t_core;
		wr(OFS_CORE_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
		rdr(OFS_CORE_CTRL);
		chk(rd, CORE_WR_MASK);
		chk({debug_port_off, global_pullup_off, vector_table_sel, vector_change_unlock}, 4'hF);
		wr(5'h14, 32'hFFFF_FFFF, RESP_SLVERR);
		rdr(5'h14);
		chk(rs, RESP_SLVERR);
		chk(rd, ZERO_WORD);
		wr(OFS_DIR, ZERO_WORD, RESP_OKAY);
		$display("core control test done");
	endtask : t_core
	task automatic t_sleep;
		@(posedge aclk) {ext_en, ext_val, ext_int_en, ext_int_edge_mode} <= 32'hFFFF_01FF;
		deep_sleep <= 1'b1;
		@(negedge aclk) chk(raw_pin_input, 8'h01);
		@(posedge aclk) {input_gate_force_en, input_gate_force_val} <= 16'h0202;
		@(negedge aclk) chk(raw_pin_input, 8'h03);
		@(posedge aclk) {input_gate_force_en, deep_sleep} <= 9'h0;
		@(negedge aclk) chk(raw_pin_input, 8'hFF);
		rdr(OFS_WAKE_FLAG);
		chk(rd, 8'hFE);
		chk(wake_int_flag, 8'hFE);
		wr(OFS_WAKE_FLAG, 8'hFF, RESP_OKAY);
		rdr(OFS_WAKE_FLAG);
		chk(rd, ZERO_WORD);
		$display("sleep test done");
	endtask : t_sleep
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_pullup();
		t_reset();
		t_drive();
		t_core();
		t_sleep();
		tally_and_finish();
	end
	initial begin
		#100us;
		err_total++;
		tally_and_finish();
	end
endmodule : port_pin_override_test

// [test/ppo_pad_model.sv]
// Purpose: pad and board model at the pin side
// Assumes: external source drives only when ext_en is set
// Notes:   a floating pin shows a changing pattern, never a held level
`timescale 1ns/10ps
module ppo_pad_model (
	input wire logic               aclk,
	input wire ppo_pkg::ppo_pins_t pad_out,
	input wire ppo_pkg::ppo_pins_t pad_oe,
	input wire ppo_pkg::ppo_pins_t pad_pullup_en,
	input wire ppo_pkg::ppo_pins_t ext_en,
	input wire ppo_pkg::ppo_pins_t ext_val,
	output ppo_pkg::ppo_pins_t     pad_in
);
	import ppo_pkg::*;
	ppo_pins_t flt_q = 8'h5A;
	always @(posedge aclk) flt_q <= ~flt_q;
	// device driver wins, then board source, then pull-up, else floating
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pad_pullup_en | flt_q));
endmodule : ppo_pad_model

// [test/ppo_props.sv]
// Purpose: port-level checks of the pin override block
// Assumes: single aclk domain, synchronous active-low reset
// Notes:   pin relations are checked bitwise on whole port vectors
`timescale 1ns/10ps
module ppo_props (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic               s_axi_rready,
	input wire logic [31:0]        s_axi_rdata,
	input wire logic               deep_sleep,
	input wire ppo_pkg::ppo_pins_t ext_int_en,
	input wire ppo_pkg::ppo_pins_t pad_in,
	input wire ppo_pkg::ppo_pins_t pad_out,
	input wire ppo_pkg::ppo_pins_t pad_oe,
	input wire ppo_pkg::ppo_pins_t pad_pullup_en,
	input wire ppo_pkg::ppo_pins_t raw_pin_input,
	input wire ppo_pkg::ppo_pins_t pad_analog_path,
	input wire ppo_pkg::ppo_pins_t pullup_force_en,
	input wire ppo_pkg::ppo_pins_t pullup_force_val,
	input wire ppo_pkg::ppo_pins_t drive_force_en,
	input wire ppo_pkg::ppo_pins_t drive_force_val,
	input wire ppo_pkg::ppo_pins_t outval_force_en,
	input wire ppo_pkg::ppo_pins_t outval_force_val,
	input wire ppo_pkg::ppo_pins_t input_gate_force_en,
	input wire ppo_pkg::ppo_pins_t input_gate_force_val
);
	import ppo_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
	sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
	pu_force_a: assert property (((pad_pullup_en ^ pullup_force_val) & pullup_force_en) == 0)
		else $error("pull-up ignores its override");
	drv_force_a: assert property (((pad_oe ^ drive_force_val) & drive_force_en) == 0)
		else $error("driver enable ignores its override");
	val_force_a: assert property (((pad_out ^ outval_force_val) & outval_force_en) == 0)
		else $error("driven value ignores its override");
	analog_path_a: assert property (pad_analog_path == pad_in)
		else $error("analog path not tied to pad");
	gate_open_a: assert property (((raw_pin_input ^ pad_in) & input_gate_force_en
		& input_gate_force_val) == 0) else $error("forced-open input not passed");
	gate_shut_a: assert property ((raw_pin_input & input_gate_force_en
		& ~input_gate_force_val) == 0) else $error("forced-shut input leaks");
	sleep_clamp_a: assert property (deep_sleep |-> (raw_pin_input & ~ext_int_en
		& ~input_gate_force_en) == 0) else $error("sleep clamp missing");
	read_answer_a: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer not next cycle");
	read_hold_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
endmodule : ppo_props
bind ppo_port_pin_override ppo_props u_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .deep_sleep, .ext_int_en, .pad_in, .pad_out,
	.pad_oe, .pad_pullup_en, .raw_pin_input, .pad_analog_path, .pullup_force_en,
	.pullup_force_val, .drive_force_en, .drive_force_val, .outval_force_en, .outval_force_val,
	.input_gate_force_en, .input_gate_force_val);

// [verilog/ppo_port_pin_override.sv]
// Purpose: one port of general I/O pins with peripheral overrides and AXI4-Lite registers
// Assumes: sleep controller, interrupt logic and peripherals share aclk
// Notes:   pad signals are split into in, out, output enable and pull-up enable
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module ppo_port_pin_override (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite slave
	input  wire logic [ppo_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [ppo_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [ppo_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [ppo_pkg::DATA_W-1:0]     s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// core state, shared by all ports
	input  wire logic                      deep_sleep,
	// external interrupt configuration per pin
	input  wire ppo_pkg::ppo_pins_t        ext_int_en,
	input  wire ppo_pkg::ppo_pins_t        ext_int_edge_mode,
	// overrides from alternate-function modules, per pin
	input  wire ppo_pkg::ppo_pins_t        pullup_force_en,
	input  wire ppo_pkg::ppo_pins_t        pullup_force_val,
	input  wire ppo_pkg::ppo_pins_t        drive_force_en,
	input  wire ppo_pkg::ppo_pins_t        drive_force_val,
	input  wire ppo_pkg::ppo_pins_t        outval_force_en,
	input  wire ppo_pkg::ppo_pins_t        outval_force_val,
	input  wire ppo_pkg::ppo_pins_t        outbit_invert_en,
	input  wire ppo_pkg::ppo_pins_t        input_gate_force_en,
	input  wire ppo_pkg::ppo_pins_t        input_gate_force_val,
	// to alternate-function modules
	output ppo_pkg::ppo_pins_t             raw_pin_input,
	output ppo_pkg::ppo_pins_t             pad_analog_path,
	// pad
	input  wire ppo_pkg::ppo_pins_t        pad_in,
	output ppo_pkg::ppo_pins_t             pad_out,
	output ppo_pkg::ppo_pins_t             pad_oe,
	output ppo_pkg::ppo_pins_t             pad_pullup_en,
	// core control outputs and wake flags
	output logic                           global_pullup_off,
	output logic                           debug_port_off,
	output logic                           vector_table_sel,
	output logic                           vector_change_unlock,
	output ppo_pkg::ppo_pins_t             wake_int_flag
);
	import ppo_pkg::*;

	// register state
	ppo_pins_t  pin_dir_bit_q,  pin_dir_bit_d;
	ppo_pins_t  pin_out_bit_q,  pin_out_bit_d;
	logic [7:0] core_ctrl_reg_q, core_ctrl_reg_d;
	ppo_pins_t  wake_flag_q,    wake_flag_d;
	ppo_pins_t  sync1_q;
	ppo_pins_t  pin_in_bit_q;
	ppo_pins_t  raw_sync1_q;
	ppo_pins_t  raw_sync2_q;
	logic       deep_sleep_q;

	// bus state
	logic                 aw_held_q;
	logic                 w_held_q;
	logic [ADDR_W-1:0]    awaddr_q;
	logic [DATA_W-1:0]    wdata_q;
	logic                 wstrb0_q;
	logic                 bvalid_q;
	logic [1:0]           bresp_q;
	logic                 rvalid_q;
	logic [DATA_W-1:0]    rdata_q;
	logic [1:0]           rresp_q;

	// per-pin combinational signals
	ppo_pins_t input_gate;
	ppo_pins_t out_value;
	ppo_pins_t pullup_req;

	// AXI handshakes
	wire aw_take   = s_axi_awvalid && s_axi_awready;
	wire w_take    = s_axi_wvalid && s_axi_wready;
	wire ar_take   = s_axi_arvalid && s_axi_arready;
	wire aw_have   = aw_held_q || aw_take;
	wire w_have    = w_held_q || w_take;
	wire wr_fire   = aw_have && w_have && !bvalid_q;

	wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire [DATA_W-1:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
	wire              wr_lane = w_held_q ? wstrb0_q : s_axi_wstrb[0];
	wire [7:0]        wr_byte = wr_data[7:0];

	// write address match
	wire wa_dir   = (wr_addr == OFS_DIR);
	wire wa_out   = (wr_addr == OFS_OUT);
	wire wa_pin   = (wr_addr == OFS_PIN);
	wire wa_core  = (wr_addr == OFS_CORE_CTRL);
	wire wa_flag  = (wr_addr == OFS_WAKE_FLAG);
	wire wr_hit   = wa_dir || wa_out || wa_pin || wa_core || wa_flag;
	wire wr_go    = wr_fire && wr_lane;

	// write decode, shared strobes for the whole port
	wire wr_dir   = wr_go && wa_dir;
	wire wr_out   = wr_go && wa_out;
	wire wr_pin   = wr_go && wa_pin;
	wire wr_core  = wr_go && wa_core;
	wire wr_flag  = wr_go && wa_flag;

	// read address match
	wire ra_dir   = (s_axi_araddr == OFS_DIR);
	wire ra_out   = (s_axi_araddr == OFS_OUT);
	wire ra_pin   = (s_axi_araddr == OFS_PIN);
	wire ra_core  = (s_axi_araddr == OFS_CORE_CTRL);
	wire ra_flag  = (s_axi_araddr == OFS_WAKE_FLAG);
	wire rd_hit   = ra_dir || ra_out || ra_pin || ra_core || ra_flag;

	// read select; an unmapped offset returns zero
	wire [7:0] rd_byte =
		ra_dir  ? pin_dir_bit_q   :
		ra_out  ? pin_out_bit_q   :
		ra_pin  ? pin_in_bit_q    :
		ra_core ? core_ctrl_reg_q :
		ra_flag ? wake_flag_q     : PIN_RESET;

	// core control bits, shared by all ports
	assign global_pullup_off    = core_ctrl_reg_q[BIT_PU_OFF];
	assign debug_port_off       = core_ctrl_reg_q[BIT_DBG_OFF];
	assign vector_table_sel     = core_ctrl_reg_q[BIT_VEC_SEL];
	assign vector_change_unlock = core_ctrl_reg_q[BIT_VEC_UNLK];
	assign wake_int_flag        = wake_flag_q;

	// only the four writable bits take bus data
	assign core_ctrl_reg_d = wr_core ? (wr_byte & CORE_WR_MASK) : core_ctrl_reg_q;

	assign pin_dir_bit_d = wr_dir ? wr_byte : pin_dir_bit_q;
	// toggle through the input bit works whatever the direction
	assign pin_out_bit_d = wr_out ? wr_byte :
	                       wr_pin ? (pin_out_bit_q ^ wr_byte) : pin_out_bit_q;

	// clamp release on wake gives the edge; set wins over a same-cycle clear
	wire       wake_edge = deep_sleep_q && !deep_sleep;
	ppo_pins_t wake_set;
	assign wake_set    = {NPIN{wake_edge}} & ext_int_edge_mode & ~ext_int_en & raw_sync2_q;
	assign wake_flag_d = (wake_flag_q & ~(wr_flag ? wr_byte : PIN_RESET)) | wake_set;

	// per-pin override logic; undriven override enables are tied low by the
	// integrator so the pin falls back to register control
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			// clamp bypassed for an enabled external interrupt; an input gate override replaces it
			wire sleep_clamp = deep_sleep && !ext_int_en[gi];
			assign input_gate[gi] = input_gate_force_en[gi] ?
			                        input_gate_force_val[gi] : !sleep_clamp;
			assign pullup_req[gi] = pullup_force_en[gi] ? pullup_force_val[gi] :
			                        (!pin_dir_bit_q[gi] && pin_out_bit_q[gi] &&
			                         !global_pullup_off);
			assign out_value[gi]  = outval_force_en[gi] ? outval_force_val[gi] :
			                        (pin_out_bit_q[gi] ^ outbit_invert_en[gi]);
			assign pad_oe[gi]     = drive_force_en[gi] ?
			                        drive_force_val[gi] : pin_dir_bit_q[gi];
		end
	endgenerate

	// pull-up forced off while reset is held
	assign pad_pullup_en   = pullup_req & {NPIN{aresetn}};
	assign pad_out         = out_value;
	// clamped input after the schmitt stage, before the synchroniser
	assign raw_pin_input   = pad_in & input_gate;
	assign pad_analog_path = pad_in;

	// AXI outputs
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// pin value synchroniser, first stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= PIN_RESET;
		end else begin
			sync1_q <= raw_pin_input;
		end
	end

	// second stage is the readable pin value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_in_bit_q <= PIN_RESET;
		end else begin
			pin_in_bit_q <= sync1_q;
		end
	end

	// unclamped pad level for wake detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_sync1_q <= PIN_RESET;
		end else begin
			raw_sync1_q <= pad_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_sync2_q <= PIN_RESET;
		end else begin
			raw_sync2_q <= raw_sync1_q;
		end
	end

	// previous sleep state, for the wake edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			deep_sleep_q <= 1'b0;
		end else begin
			deep_sleep_q <= deep_sleep;
		end
	end

	// software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_dir_bit_q <= PIN_RESET;
		end else begin
			pin_dir_bit_q <= pin_dir_bit_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_bit_q <= PIN_RESET;
		end else begin
			pin_out_bit_q <= pin_out_bit_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_ctrl_reg_q <= CORE_RESET;
		end else begin
			core_ctrl_reg_q <= core_ctrl_reg_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_flag_q <= PIN_RESET;
		end else begin
			wake_flag_q <= wake_flag_d;
		end
	end

	// write address and data holding until both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
		end else begin
			aw_held_q <= aw_have && !wr_fire;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
		end else begin
			w_held_q <= w_have && !wr_fire;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= '0;
		end else if (aw_take) begin
			awaddr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdata_q  <= ZERO_WORD;
			wstrb0_q <= 1'b0;
		end else if (w_take) begin
			wdata_q  <= s_axi_wdata;
			wstrb0_q <= s_axi_wstrb[0];
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_q <= ZERO_WORD;
		end else if (ar_take) begin
			rdata_q <= {ZERO_PAD24, rd_byte};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rresp_q <= RESP_OKAY;
		end else if (ar_take) begin
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end
endmodule : ppo_port_pin_override
